// ===== dv/timer_group_assertions.sv
// Purpose: Port checks of the timer group.
// Assumes: One clock domain and an asynchronous active low reset.
// Notes: Start and mask are shadowed from bus writes, so faults show against software's view.
`timescale 1ns/1ps
module timer_group_assertions (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [7:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [15:0] RDATA,
	input wire logic SUBCLOCK,
	input wire logic TRIGGER,
	input wire logic B_TIMER_INPUT_PIN,
	input wire logic PWM_PULSE_PIN,
	input wire logic IRQ
);
	logic start_a_q;
	logic [1:0] mask_q;
	logic [3:0] pin_q;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			start_a_q <= 1'b0;
			mask_q <= 2'h0;
			pin_q <= 4'h0;
		end else begin
			pin_q <= {pin_q[2:0], B_TIMER_INPUT_PIN};
			if (WR && ADDR == timer_group_pkg::START_OFS) begin
				start_a_q <= WDATA[0];
			end
			if (WR && ADDR == timer_group_pkg::INT_MASK_OFS) begin
				mask_q <= WDATA[1:0];
			end
		end
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 16'h0000)
		else $error("read data not zero outside an answer");
	AST_A_READ_UNDEF: assert property (
		$past(RD) && $past(ADDR) == timer_group_pkg::A_VALUE_OFS
		|-> RDATA == timer_group_pkg::A_READ_UNDEF) else $error("A value read shows a count");
	AST_UNMAPPED_ZERO: assert property ($past(RD) && $past(ADDR) > 8'h1c |-> RDATA == 16'h0000)
		else $error("unmapped read not zero");
	AST_FLAG_WIDTH: assert property ($past(RD) && ($past(ADDR) == timer_group_pkg::START_OFS
		|| $past(ADDR) == timer_group_pkg::INT_STATUS_OFS) |-> RDATA[15:2] == 14'h0)
		else $error("flag register upper bits set");
	AST_PORT_PIN: assert property (
		$past(RD) && $past(ADDR) == timer_group_pkg::PORT_OFS && (pin_q == 4'h0 || pin_q == 4'hf)
		|-> RDATA[0] == pin_q[0]) else $error("port bit differs from input pin");
	AST_STOP_PIN: assert property (
		WR && ADDR == timer_group_pkg::START_OFS && !WDATA[0] |-> ##2 !PWM_PULSE_PIN)
		else $error("pulse pin high after stop");
	AST_STOPPED_LOW: assert property (!start_a_q && !$past(start_a_q) |-> !PWM_PULSE_PIN)
		else $error("pulse pin high while stopped");
	AST_IRQ_MASKED: assert property (mask_q == 2'h0 && $past(mask_q) == 2'h0 |-> !IRQ)
		else $error("interrupt high with mask clear");
	AST_PWM_FALL_IRQ: assert property (
		$fell(PWM_PULSE_PIN) && start_a_q && mask_q[0] && $past(mask_q[0]) |-> ##2 IRQ)
		else $error("no interrupt after pulse fall");
endmodule
bind timer_group timer_group_assertions i_chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SUBCLOCK(SUBCLOCK), .TRIGGER(TRIGGER),
	.B_TIMER_INPUT_PIN(B_TIMER_INPUT_PIN), .PWM_PULSE_PIN(PWM_PULSE_PIN), .IRQ(IRQ));

// ===== dv/timer_group_test.sv
// Purpose: Self-checking bench of the timer group.
// Assumes: Bus tasks hold each strobe exactly one cycle.
// Notes: One full 16-bit period is run, which dominates the run time.
`timescale 1ns/1ps
module timer_group_test;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic [7:0] ADDR = 8'h00;
	logic [15:0] WDATA = 16'h0000;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic [15:0] RDATA;
	logic SUBCLOCK = 1'b0;
	logic TRIGGER = 1'b0;
	logic B_TIMER_INPUT_PIN = 1'b0;
	logic PWM_PULSE_PIN;
	logic IRQ;
	int errors = 0;
	int cmp_count = 0;
	int run_n = 0;
	int hi_len = 0;
	int lo_len = 0;
	logic pin_prev = 1'b0;
	logic [15:0] v1;
	logic [15:0] v2;

	timer_group i_dut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .SUBCLOCK(SUBCLOCK), .TRIGGER(TRIGGER),
		.B_TIMER_INPUT_PIN(B_TIMER_INPUT_PIN), .PWM_PULSE_PIN(PWM_PULSE_PIN), .IRQ(IRQ));

	always #10 CLK = ~CLK;
	always @(posedge CLK) SUBCLOCK <= ~SUBCLOCK;
	// Run lengths are recorded as each run ends, so tasks never race the pin.
	always @(posedge CLK) begin
		if (PWM_PULSE_PIN === pin_prev) begin
			run_n++;
		end else begin
			if (pin_prev) begin
				hi_len = run_n;
			end else begin
				lo_len = run_n;
			end
			run_n = 1;
		end
		pin_prev = PWM_PULSE_PIN;
	end

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge CLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CLK);
		WR <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge CLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge CLK);
		RD <= 1'b0;
		@(posedge CLK);
		d = RDATA;
	endtask

	task automatic wait_for(input bit irq, input logic lvl);
		int i;
		for (i = 0; i < 70000; i++) begin
			if ((irq ? IRQ : PWM_PULSE_PIN) === lvl) break;
			@(posedge CLK);
		end
		if (i == 70000) begin
			errors++;
			$display("unexpected wait: expected level %b seen timeout", lvl);
			tally_and_finish();
		end
	endtask

	task automatic t_reset();
		wr(8'h20, 16'hffff);
		for (int k = 0; k < 9; k++) begin
			rd(8'(k * 4), v1);
			check("reset read", 16'h0000, v1);
		end
		B_TIMER_INPUT_PIN <= 1'b1;
		repeat (4) @(posedge CLK);
		rd(8'h1c, v1);
		check("port pin", 16'h0001, v1 & 16'h0001);
		B_TIMER_INPUT_PIN <= 1'b0;
		$display("reset test done");
	endtask

	task automatic t_pwm16();
		wr(8'h18, 16'h0001);
		wr(8'h00, 16'h0005);
		wr(8'h10, 16'h0001);
		wr(8'h00, 16'h0003);
		wait_for(0, 1'b0);
		@(posedge CLK);
		check("high 16", 16'd5, 16'(hi_len));
		wait_for(1, 1'b1);
		rd(8'h14, v1);
		check("status", 16'h0001, v1);
		wr(8'h14, 16'h0001);
		rd(8'h14, v1);
		check("status clear", 16'h0000, v1);
		wait_for(0, 1'b1);
		@(posedge CLK);
		check("low 16", 16'd65530, 16'(lo_len));
		wait_for(0, 1'b0);
		@(posedge CLK);
		check("new high 16", 16'd3, 16'(hi_len));
		rd(8'h00, v1);
		check("A read", timer_group_pkg::A_READ_UNDEF, v1);
		wr(8'h10, 16'h0000);
		wr(8'h14, 16'h0003);
		$display("pwm16 test done");
	endtask

	task automatic pulse();
		@(posedge CLK);
		TRIGGER <= 1'b1;
		@(posedge CLK);
		TRIGGER <= 1'b0;
	endtask

	task automatic t_pwm8();
		wr(8'h18, 16'h0000);
		wr(8'h04, 16'h000c);
		wr(8'h00, 16'h0201);
		wr(8'h10, 16'h0001);
		repeat (10) @(posedge CLK);
		check("waits trigger", 16'h0000, {15'h0, PWM_PULSE_PIN});
		pulse();
		wait_for(0, 1'b1);
		pulse();
		wait_for(0, 1'b0);
		@(posedge CLK);
		check("high 8", 16'd4, 16'(hi_len));
		repeat (3) @(posedge CLK);
		check("masked irq", 16'h0000, {15'h0, IRQ});
		rd(8'h14, v1);
		check("status 8", 16'h0001, v1);
		wr(8'h18, 16'h0001);
		repeat (3) @(posedge CLK);
		check("unmasked irq", 16'h0001, {15'h0, IRQ});
		wait_for(0, 1'b1);
		@(posedge CLK);
		check("low 8", 16'd506, 16'(lo_len));
		wr(8'h10, 16'h0000);
		wr(8'h14, 16'h0001);
		wr(8'h18, 16'h0000);
		$display("pwm8 test done");
	endtask

	// The trigger lands four cycles into a six-cycle shot, so the run stretches to ten.
	task automatic t_oneshot();
		wr(8'h04, 16'h0010);
		wr(8'h00, 16'h0006);
		wr(8'h10, 16'h0001);
		repeat (3) @(posedge CLK);
		pulse();
		wait_for(0, 1'b0);
		@(posedge CLK);
		check("one-shot high", 16'd10, 16'(hi_len));
		repeat (20) @(posedge CLK);
		check("one-shot rest", 16'h0000, {15'h0, PWM_PULSE_PIN});
		wr(8'h10, 16'h0000);
		wr(8'h14, 16'h0001);
		$display("one-shot test done");
	endtask

	task automatic t_btimer();
		wr(8'h0c, 16'h0004);
		wr(8'h08, 16'h0004);
		rd(8'h08, v1);
		check("B load", 16'h0004, v1);
		wr(8'h18, 16'h0002);
		wr(8'h10, 16'h0002);
		wait_for(1, 1'b1);
		rd(8'h14, v1);
		check("B status", 16'h0002, v1);
		wr(8'h14, 16'h0002);
		rd(8'h08, v1);
		repeat (5) @(posedge CLK);
		rd(8'h08, v2);
		check("B step", (v1 == 16'h0) ? 16'h0004 : v1 - 16'h1, v2);
		rd(8'h08, v1);
		repeat (37) @(posedge CLK);
		rd(8'h08, v2);
		check("B period", v1, v2);
		wr(8'h08, 16'h0002);
		repeat (50) @(posedge CLK);
		rd(8'h08, v1);
		check("B new reload", 16'h0001, {15'h0, v1 <= 16'h0002});
		wr(8'h10, 16'h0000);
		rd(8'h08, v1);
		repeat (13) @(posedge CLK);
		rd(8'h08, v2);
		check("B stopped", v1, v2);
		wr(8'h0c, 16'h0005);
		wr(8'h10, 16'h0002);
		rd(8'h08, v1);
		repeat (13) @(posedge CLK);
		rd(8'h08, v2);
		check("B event mode", v1, v2);
		wr(8'h10, 16'h0000);
		wr(8'h08, 16'h0001);
		wr(8'h0c, 16'h0008);
		wr(8'h10, 16'h0002);
		rd(8'h08, v1);
		repeat (29) @(posedge CLK);
		rd(8'h08, v2);
		check("B div32 step", {15'h0, ~v1[0]}, v2);
		wr(8'h0c, 16'h000c);
		rd(8'h08, v1);
		repeat (61) @(posedge CLK);
		rd(8'h08, v2);
		check("B sub32 step", {15'h0, ~v1[0]}, v2);
		wr(8'h10, 16'h0000);
		wr(8'h14, 16'h0002);
		wr(8'h18, 16'h0000);
		$display("B timer test done");
	endtask

	initial begin
		repeat (12) @(posedge CLK);
		RST_N <= 1'b1;
		t_reset();
		t_pwm16();
		t_pwm8();
		t_oneshot();
		t_btimer();
		tally_and_finish();
	end
endmodule

// ===== rtl/count_clock_gen.sv
// Purpose: Count clock strobes from the system clock and the subclock.
// Assumes: SUBCLOCK is sampled as a synchronous input.
// Notes: Each strobe is one CLK cycle wide.
`timescale 1ns/1ps
module count_clock_gen #(
	parameter int DIV8 = timer_group_pkg::DIV8_COUNT,
	parameter int DIV32 = timer_group_pkg::DIV32_COUNT
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic subclock,
	output timer_group_pkg::ticks_t ticks
);

	logic [4:0] div8_q;
	logic [4:0] div32_q;
	logic [4:0] sub_q;
	logic sub_prev_q;
	logic sub_rise;
	timer_group_pkg::ticks_t ticks_q;

	assign sub_rise = subclock && !sub_prev_q;
	assign ticks = ticks_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div8_q <= 5'h00;
			div32_q <= 5'h00;
		end else begin
			div8_q <= (div8_q == 5'(DIV8 - 1)) ? 5'h00 : div8_q + 5'h01;
			div32_q <= (div32_q == 5'(DIV32 - 1)) ? 5'h00 : div32_q + 5'h01;
		end
	end

	// The subclock is far slower than CLK, so its edges are counted, not used as a clock.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sub_prev_q <= 1'b0;
			sub_q <= 5'h00;
		end else begin
			sub_prev_q <= subclock;
			if (sub_rise) begin
				sub_q <= (sub_q == 5'(DIV32 - 1)) ? 5'h00 : sub_q + 5'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ticks_q <= '0;
		end else begin
			ticks_q.div1 <= 1'b1;
			ticks_q.div8 <= (div8_q == 5'(DIV8 - 1));
			ticks_q.div32 <= (div32_q == 5'(DIV32 - 1));
			ticks_q.sub32 <= sub_rise && (sub_q == 5'(DIV32 - 1));
		end
	end

endmodule

// ===== rtl/timer_group.sv
// Purpose: One PWM capable A-type timer and one interval B-type timer.
// Assumes: Register port with one-cycle strobes; read data valid the cycle after.
// Notes: Other B timer modes answer as idle counters; the A timer also runs a one-shot mode.
// Function
// [RL1] A timer in PWM mode counts down as a 16-bit or 8-bit modulator.
// [RL2] PWM reloads the count on every rising pulse edge and keeps counting.
// [RL3] Triggers arriving during a running PWM count are ignored.
// [RL4] 16-bit PWM high time is n clocks, period 65535 clocks.
// [RL5] 8-bit PWM high time n(m+1) clocks, period 255(m+1) clocks.
// [RL6] A timer starts when its start flag is 1, halts at 0.
// [RL7] PWM interrupt request is raised when the pulse falls.
// [RL8] Reading the A timer value in PWM mode returns an undefined value.
// [RL9] A timer value write while stopped loads reload register and counter.
// [RL10] A timer value write while counting loads reload only, used next reload.
// [RL11] B timer mode comes from mode register bits 0 and 1.
// [RL12] B timer in timer mode counts down a selected internal count clock.
// [RL13] B underflow reloads, continues counting and raises the interrupt request.
// [RL14] B timer divides its count clock by n plus one.
// [RL15] B timer runs while its start flag is 1, stops at 0.
// [RL16] Reading the B timer value in timer mode returns the current count.
// [RL17] B value write loads both when stopped, only reload while counting.
// [RL18] PWM pin carries the pulse; B input pin stays a plain port.
// [RL19] A trigger during a running one-shot count reloads and restarts it.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
module timer_group (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [timer_group_pkg::ADDR_W-1:0] ADDR,
	input wire logic [timer_group_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [timer_group_pkg::DATA_W-1:0] RDATA,
	input wire logic SUBCLOCK,
	input wire logic TRIGGER,
	input wire logic B_TIMER_INPUT_PIN,
	output logic PWM_PULSE_PIN,
	output logic IRQ
);

	typedef enum logic [2:0] {
		A_IDLE = 3'b000,
		A_WAIT_TRIG = 3'b001,
		A_HIGH = 3'b010,
		A_LOW = 3'b011,
		A_SHOT = 3'b100
	} a_state_t;

	timer_group_pkg::ticks_t ticks;
	timer_group_pkg::a_mode_t a_mode_q;
	timer_group_pkg::b_mode_t b_mode_q;
	a_state_t a_state_q;
	logic [15:0] a_reload_q;
	logic [15:0] a_cnt_q;
	logic [15:0] a_hi_q;
	logic [7:0] a_pre_q;
	logic [7:0] a_m_q;
	logic a_out_q;
	logic a_evt_q;
	logic [15:0] b_reload_q;
	logic [15:0] b_cnt_q;
	logic b_evt_q;
	logic [1:0] start_q;
	logic [1:0] status_q;
	logic [1:0] mask_q;
	logic [1:0] status_d;
	logic [15:0] rdata_q;
	logic irq_q;
	logic pin_q;

	logic wr_a_value;
	logic wr_b_value;
	logic a_tick;
	logic a_unit;
	logic a_counting;
	logic b_tick;
	logic b_counting;
	logic [15:0] hi_n;
	logic [15:0] period;
	logic [15:0] low_len;
	a_state_t rise_state;
	logic [15:0] rise_cnt;
	logic rise_out;

	function automatic logic pick_tick(input timer_group_pkg::ticks_t t,
		input timer_group_pkg::src_t s);
		case (s)
			timer_group_pkg::SRC_DIV1: pick_tick = t.div1;
			timer_group_pkg::SRC_DIV8: pick_tick = t.div8;
			timer_group_pkg::SRC_DIV32: pick_tick = t.div32;
			timer_group_pkg::SRC_SUB32: pick_tick = t.sub32;
			default: pick_tick = 1'b0;
		endcase
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	count_clock_gen #(
		.DIV8(timer_group_pkg::DIV8_COUNT),
		.DIV32(timer_group_pkg::DIV32_COUNT)
	) u_clocks (
		.clk(CLK),
		.rst_n(RST_N),
		.subclock(SUBCLOCK),
		.ticks(ticks)
	);

	assign wr_a_value = WR && hit(ADDR, timer_group_pkg::A_VALUE_OFS);
	assign wr_b_value = WR && hit(ADDR, timer_group_pkg::B_VALUE_OFS);
	// [RL12] count clock select
	assign a_tick = pick_tick(ticks, a_mode_q.src);
	assign b_tick = pick_tick(ticks, b_mode_q.src);
	assign a_counting = (a_state_q == A_HIGH) || (a_state_q == A_LOW) || (a_state_q == A_SHOT);
	// [RL11] [RL15] mode bits, start flag
	assign b_counting = start_q[timer_group_pkg::START_B_BIT] &&
		(b_mode_q.op == timer_group_pkg::B_OP_TIMER);

	// [RL5] prescaler by m plus one
	assign a_unit = a_mode_q.pwm8 ? (a_tick && (a_pre_q == 8'h00)) : a_tick;
	// [RL1] width select
	assign hi_n = a_mode_q.pwm8 ? {8'h00, a_reload_q[15:8]} : a_reload_q;
	// [RL4] fixed period
	assign period = a_mode_q.pwm8 ? timer_group_pkg::PWM8_PERIOD : timer_group_pkg::PWM16_PERIOD;
	assign low_len = period - a_hi_q;

	// Values taken at a rising pulse edge, shared by the first start and every reload.
	always_comb begin
		if (a_mode_q.oneshot) begin
			rise_state = A_SHOT;
			rise_cnt = a_reload_q;
			rise_out = 1'b1;
		end else if (hi_n == 16'h0000) begin
			rise_state = A_LOW;
			rise_cnt = period;
			rise_out = 1'b0;
		end else begin
			rise_state = A_HIGH;
			rise_cnt = hi_n;
			rise_out = 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			a_mode_q <= timer_group_pkg::A_MODE_RST;
			b_mode_q <= timer_group_pkg::B_MODE_RST;
			start_q <= timer_group_pkg::START_RST;
			mask_q <= timer_group_pkg::INT_RST;
		end else if (WR) begin
			if (hit(ADDR, timer_group_pkg::A_MODE_OFS)) begin
				a_mode_q <= WDATA[$bits(timer_group_pkg::a_mode_t)-1:0];
			end
			if (hit(ADDR, timer_group_pkg::B_MODE_OFS)) begin
				b_mode_q <= WDATA[$bits(timer_group_pkg::b_mode_t)-1:0];
			end
			if (hit(ADDR, timer_group_pkg::START_OFS)) begin
				start_q <= WDATA[1:0];
			end
			if (hit(ADDR, timer_group_pkg::INT_MASK_OFS)) begin
				mask_q <= WDATA[1:0];
			end
		end
	end

	// [RL10] reload register always takes the write
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			a_reload_q <= timer_group_pkg::A_VALUE_RST;
		end else if (wr_a_value) begin
			a_reload_q <= WDATA;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			a_state_q <= A_IDLE;
			a_cnt_q <= timer_group_pkg::A_VALUE_RST;
			a_hi_q <= 16'h0000;
			a_m_q <= 8'h00;
			a_pre_q <= 8'h00;
			a_out_q <= 1'b0;
			a_evt_q <= 1'b0;
		end else begin
			a_evt_q <= 1'b0;
			if (!start_q[timer_group_pkg::START_A_BIT]) begin
				// [RL6] stop on flag clear
				a_state_q <= A_IDLE;
				a_out_q <= 1'b0;
				if (wr_a_value) begin
					// [RL9] stopped write loads counter
					a_cnt_q <= WDATA;
				end
			end else begin
				case (a_state_q)
					A_IDLE, A_WAIT_TRIG: begin
						if (wr_a_value) begin
							a_cnt_q <= WDATA;
						end
						// [RL6] start on flag set
						if ((a_state_q == A_IDLE && !a_mode_q.trig_sel) || TRIGGER) begin
							a_state_q <= rise_state;
							a_cnt_q <= rise_cnt;
							a_out_q <= rise_out;
							a_hi_q <= hi_n;
							a_m_q <= a_reload_q[7:0];
							a_pre_q <= a_reload_q[7:0];
						end else begin
							a_state_q <= A_WAIT_TRIG;
						end
					end
					A_HIGH: begin
						// [RL3] triggers ignored while PWM counting
						if (a_tick) begin
							a_pre_q <= (a_pre_q == 8'h00) ? a_m_q : a_pre_q - 8'h01;
						end
						if (a_unit && a_cnt_q <= 16'h0001) begin
							if (low_len == 16'h0000) begin
								a_cnt_q <= rise_cnt;
								a_hi_q <= hi_n;
							end else begin
								// [RL7] request on falling pulse
								a_state_q <= A_LOW;
								a_cnt_q <= low_len;
								a_out_q <= 1'b0;
								a_evt_q <= 1'b1;
							end
						end else if (a_unit) begin
							a_cnt_q <= a_cnt_q - 16'h0001;
						end
					end
					A_LOW: begin
						if (a_tick) begin
							a_pre_q <= (a_pre_q == 8'h00) ? a_m_q : a_pre_q - 8'h01;
						end
						if (a_unit && a_cnt_q <= 16'h0001) begin
							// [RL2] reload at rising edge
							a_state_q <= rise_state;
							a_cnt_q <= rise_cnt;
							a_out_q <= rise_out;
							a_hi_q <= hi_n;
							a_m_q <= a_reload_q[7:0];
							a_pre_q <= a_reload_q[7:0];
						end else if (a_unit) begin
							a_cnt_q <= a_cnt_q - 16'h0001;
						end
					end
					A_SHOT: begin
						if (TRIGGER) begin
							// [RL19] retrigger reloads
							a_cnt_q <= a_reload_q;
						end else if (a_tick && a_cnt_q <= 16'h0001) begin
							a_state_q <= A_WAIT_TRIG;
							a_cnt_q <= a_reload_q;
							a_out_q <= 1'b0;
							a_evt_q <= 1'b1;
						end else if (a_tick) begin
							a_cnt_q <= a_cnt_q - 16'h0001;
						end
					end
					default: begin
						a_state_q <= A_IDLE;
						a_out_q <= 1'b0;
					end
				endcase
			end
		end
	end

	// [RL17] reload register always takes the write
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			b_reload_q <= timer_group_pkg::B_VALUE_RST;
		end else if (wr_b_value) begin
			b_reload_q <= WDATA;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			b_cnt_q <= timer_group_pkg::B_VALUE_RST;
			b_evt_q <= 1'b0;
		end else begin
			b_evt_q <= 1'b0;
			if (!b_counting) begin
				// [RL17] stopped write loads counter
				if (wr_b_value) begin
					b_cnt_q <= WDATA;
				end
			end else if (b_tick) begin
				// [RL13] underflow reloads and requests
				if (b_cnt_q == 16'h0000) begin
					b_cnt_q <= b_reload_q;
					b_evt_q <= 1'b1;
				end else begin
					// [RL14] n plus one counts per underflow
					b_cnt_q <= b_cnt_q - 16'h0001;
				end
			end
		end
	end

	// A set arriving with its write-one clear wins, so no event is lost.
	always_comb begin
		status_d = status_q;
		if (WR && hit(ADDR, timer_group_pkg::INT_STATUS_OFS)) begin
			status_d = status_d & ~WDATA[1:0];
		end
		status_d[timer_group_pkg::INT_A_BIT] = status_d[timer_group_pkg::INT_A_BIT] | a_evt_q;
		status_d[timer_group_pkg::INT_B_BIT] = status_d[timer_group_pkg::INT_B_BIT] | b_evt_q;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			status_q <= timer_group_pkg::INT_RST;
			irq_q <= 1'b0;
		end else begin
			status_q <= status_d;
			irq_q <= |(status_d & mask_q);
		end
	end

	// [RL18] input pin readable as a plain port
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= B_TIMER_INPUT_PIN;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_q <= 16'h0000;
		end else if (RD) begin
			case (ADDR)
				// [RL8] counter not visible in PWM mode
				timer_group_pkg::A_VALUE_OFS: rdata_q <= timer_group_pkg::A_READ_UNDEF;
				timer_group_pkg::A_MODE_OFS: rdata_q <= 16'(a_mode_q);
				// [RL16] live count readback
				timer_group_pkg::B_VALUE_OFS: rdata_q <= b_cnt_q;
				timer_group_pkg::B_MODE_OFS: rdata_q <= 16'(b_mode_q);
				timer_group_pkg::START_OFS: rdata_q <= {14'h0000, start_q};
				timer_group_pkg::INT_STATUS_OFS: rdata_q <= {14'h0000, status_q};
				timer_group_pkg::INT_MASK_OFS: rdata_q <= {14'h0000, mask_q};
				timer_group_pkg::PORT_OFS: rdata_q <= {13'h0000, a_counting, a_out_q, pin_q};
				default: rdata_q <= 16'h0000;
			endcase
		end else begin
			rdata_q <= 16'h0000;
		end
	end

	assign RDATA = rdata_q;
	// [RL18] pulse train on the pin
	assign PWM_PULSE_PIN = a_out_q;
	assign IRQ = irq_q;

endmodule

// ===== rtl/timer_group_pkg.sv
// Purpose: Shared constants and types of the PWM and interval timer group.
// Assumes: 16-bit register data, byte addresses on an 8-bit register port.
// Notes: Offsets are byte addresses of one 16-bit register each.
package timer_group_pkg;

	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;

	localparam logic [7:0] A_VALUE_OFS = 8'h00;
	localparam logic [7:0] A_MODE_OFS = 8'h04;
	localparam logic [7:0] B_VALUE_OFS = 8'h08;
	localparam logic [7:0] B_MODE_OFS = 8'h0c;
	localparam logic [7:0] START_OFS = 8'h10;
	localparam logic [7:0] INT_STATUS_OFS = 8'h14;
	localparam logic [7:0] INT_MASK_OFS = 8'h18;
	localparam logic [7:0] PORT_OFS = 8'h1c;

	localparam int START_A_BIT = 0;
	localparam int START_B_BIT = 1;
	localparam int INT_A_BIT = 0;
	localparam int INT_B_BIT = 1;

	localparam logic [15:0] A_VALUE_RST = 16'h0000;
	localparam logic [15:0] B_VALUE_RST = 16'h0000;
	localparam logic [1:0] START_RST = 2'h0;
	localparam logic [1:0] INT_RST = 2'h0;
	localparam logic [15:0] A_READ_UNDEF = 16'h0000;

	localparam logic [15:0] PWM16_PERIOD = 16'hffff;
	localparam logic [15:0] PWM8_PERIOD = 16'h00ff;
	localparam int DIV8_COUNT = 8;
	localparam int DIV32_COUNT = 32;

	typedef enum logic [1:0] {
		SRC_DIV1 = 2'b00,
		SRC_DIV8 = 2'b01,
		SRC_DIV32 = 2'b10,
		SRC_SUB32 = 2'b11
	} src_t;

	typedef enum logic [1:0] {
		B_OP_TIMER = 2'b00,
		B_OP_EVENT = 2'b01,
		B_OP_MEASURE = 2'b10,
		B_OP_RESERVED = 2'b11
	} b_op_t;

	typedef struct packed {
		logic oneshot;
		logic trig_sel;
		logic pwm8;
		src_t src;
	} a_mode_t;

	typedef struct packed {
		src_t src;
		b_op_t op;
	} b_mode_t;

	typedef struct packed {
		logic div1;
		logic div8;
		logic div32;
		logic sub32;
	} ticks_t;

	localparam a_mode_t A_MODE_RST = '{oneshot: 1'b0, trig_sel: 1'b0, pwm8: 1'b0, src: SRC_DIV1};
	localparam b_mode_t B_MODE_RST = '{src: SRC_DIV1, op: B_OP_TIMER};

endpackage
